/* File: hdl/hpr_cfg.svh */
// Purpose: constants for the home position return block
// Assumes: configuration word laid out as four 4-bit digits
// Notes:   digit 0 method, digit 1 direction, digit 2 dog polarity
`ifndef HPR_CFG_SVH
`define HPR_CFG_SVH
`define HPR_METHOD_LSB   0
`define HPR_DIR_BIT      4
`define HPR_POL_BIT      8
`define HPR_METHOD_W     3
`define HPR_STOP_NS      20000
`define HPR_CLK_NS       20
`define HPR_STOP_CYC     (`HPR_STOP_NS / `HPR_CLK_NS)
`endif

/* File: hdl/hpr_pkg.sv */
// Purpose: types for the home position return block
// Assumes: nothing
// Notes:   method codes follow the configuration low digit
package hpr_pkg;
   typedef enum logic [2:0] {
      HPR_M_DOG      = 3'h0,
      HPR_M_COUNT    = 3'h1,
      HPR_M_DATA     = 3'h2,
      HPR_M_STOPPER  = 3'h3,
      HPR_M_IGNORE   = 3'h4,
      HPR_M_REAR_REF = 3'h5,
      HPR_M_FRONT_REF = 3'h6,
      HPR_M_CRADLE   = 3'h7
   } hpr_method_type;
   typedef enum logic [2:0] {
      HPR_IDLE   = 3'h0,
      HPR_SEEK   = 3'h1,
      HPR_ON_DOG = 3'h2,
      HPR_TRAVEL = 3'h3,
      HPR_WAIT_Z = 3'h4,
      HPR_SHIFT  = 3'h5,
      HPR_DONE   = 3'h6
   } hpr_state_type;
endpackage : hpr_pkg

/* File: hdl/hpr_home_return.sv */
// Purpose: home position return sequencer for one servo axis
// Assumes: position feedback steps of one unit, index pulse from an input
// Notes:   motion outputs are requests to the position controller
`timescale 1ns/10ps
`include "hpr_cfg.svh"
module hpr_home_return
   import hpr_pkg::*;
#(
   parameter int POS_W    = 32,
   parameter int STOP_CYC = `HPR_STOP_CYC
)(
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               rstn,
   // Configuration
   input  wire logic [15:0]        home_config,
   input  wire logic [POS_W-1:0]   home_coord,
   input  wire logic [POS_W-1:0]   after_dog_dist,
   input  wire logic [POS_W-1:0]   shift_dist,
   // Control
   input  wire logic               auto_manual_select,
   input  wire logic               homing_program_command,
   input  wire logic               servo_on,
   // Sensors and feedback
   input  wire logic               dog_in,
   input  wire logic               index_pulse,
   input  wire logic               axis_moving,
   input  wire logic               pos_step,
   // Motion requests
   output logic                    move_req,
   output logic                    move_dir_dec,
   output logic                    creep_req,
   // Position and status
   output logic [POS_W-1:0]        cur_pos,
   output logic                    home_done,
   output logic                    homing_busy
);

   // ****************************************
   // Configuration decode
   // ****************************************
   hpr_method_type   method;
   logic             dog_hit;
   logic             dog_q;
   logic             dog_front;
   logic             dog_rear;
   logic             start;
   logic             servo_on_q;
   logic             servo_rise;
   assign method     = hpr_method_type'(home_config[`HPR_METHOD_LSB +: `HPR_METHOD_W]);
   assign dog_hit    = home_config[`HPR_POL_BIT] ? dog_in : ~dog_in;
   assign dog_front  = dog_hit & ~dog_q;
   assign dog_rear   = ~dog_hit & dog_q;
   assign start      = homing_program_command & auto_manual_select;
   assign servo_rise = servo_on & ~servo_on_q;

   // ****************************************
   // Sequencer
   // ****************************************
   hpr_state_type         state_q, state_d;
   logic [POS_W-1:0]      dist_q, dist_d;
   logic [15:0]           stall_q;
   logic                  stalled;
   logic                  uses_index;
   logic                  set_home;
   assign stalled    = (stall_q >= 16'(STOP_CYC));
   assign uses_index = (method == HPR_M_DOG) || (method == HPR_M_COUNT) || (method == HPR_M_CRADLE);

   // Next state: index is consumed here only, never driven out
   always_comb begin
      state_d  = state_q;
      dist_d   = dist_q;
      set_home = 1'b0;
      case (state_q)
         // A start from rest or after a finished run decodes the method afresh
         HPR_IDLE, HPR_DONE: begin
            if (start) begin
               case (method)
                  HPR_M_DATA: state_d = HPR_DONE;
                  HPR_M_IGNORE: state_d = HPR_IDLE;
                  default: state_d = HPR_SEEK;
               endcase
               if (method == HPR_M_DATA) set_home = 1'b1;
            end
         end
         HPR_SEEK: begin
            if (method == HPR_M_STOPPER) begin
               if (stalled) begin
                  state_d  = HPR_DONE;
                  set_home = 1'b1;
               end
            end else if (dog_front) begin
               case (method)
                  HPR_M_COUNT, HPR_M_FRONT_REF: begin
                     state_d = HPR_TRAVEL;
                     dist_d  = after_dog_dist;
                  end
                  HPR_M_CRADLE: state_d = HPR_WAIT_Z;
                  default: state_d = HPR_ON_DOG;
               endcase
            end
         end
         HPR_ON_DOG: begin
            if (dog_rear) begin
               if (method == HPR_M_REAR_REF) begin
                  state_d = HPR_TRAVEL;
                  dist_d  = after_dog_dist;
               end else begin
                  state_d = HPR_WAIT_Z;
               end
            end
         end
         HPR_TRAVEL: begin
            if (dist_q == '0) begin
               if (method == HPR_M_COUNT) begin
                  state_d = HPR_WAIT_Z;
               end else begin
                  state_d = HPR_SHIFT;
                  dist_d  = shift_dist;
               end
            end else if (pos_step) begin
               dist_d = dist_q - 1'b1;
            end
         end
         HPR_WAIT_Z: begin
            if (index_pulse) begin
               state_d = HPR_SHIFT;
               dist_d  = (method == HPR_M_CRADLE) ? '0 : shift_dist;
            end
         end
         HPR_SHIFT: begin
            if (dist_q == '0) begin
               state_d  = HPR_DONE;
               set_home = 1'b1;
            end else if (pos_step) begin
               dist_d = dist_q - 1'b1;
            end
         end
         default: state_d = HPR_IDLE;
      endcase
   end

   // State and edge history
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q    <= HPR_IDLE;
         dist_q     <= '0;
         dog_q      <= 1'b0;
         servo_on_q <= 1'b0;
      end else begin
         state_q    <= state_d;
         dist_q     <= dist_d;
         dog_q      <= dog_hit;
         servo_on_q <= servo_on;
      end
   end

   // Stall timer: a stopper stop is seen as no motion for a while
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stall_q <= '0;
      end else if (state_q != HPR_SEEK || axis_moving) begin
         stall_q <= '0;
      end else if (!stalled) begin
         stall_q <= stall_q + 16'h0001;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   logic  ignore_home;
   assign ignore_home = (method == HPR_M_IGNORE) && servo_rise;

   // Position: counts steps, reloads the home coordinate at home
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cur_pos <= '0;
      end else if (set_home || ignore_home) begin
         cur_pos <= home_coord;
      end else if (pos_step) begin
         cur_pos <= home_config[`HPR_DIR_BIT] ? cur_pos - 1'b1 : cur_pos + 1'b1;
      end
   end

   // Flags and motion requests; a new start clears done unless home is set in the same cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         home_done    <= 1'b0;
         homing_busy  <= 1'b0;
         move_req     <= 1'b0;
         creep_req    <= 1'b0;
         move_dir_dec <= 1'b0;
      end else begin
         if (set_home || ignore_home) home_done <= 1'b1;
         else if (start) home_done <= 1'b0;
         homing_busy  <= (state_d != HPR_IDLE) && (state_d != HPR_DONE);
         move_req     <= (state_d != HPR_IDLE) && (state_d != HPR_DONE);
         creep_req    <= (state_d != HPR_IDLE) && (state_d != HPR_DONE) && (state_d != HPR_SEEK);
         move_dir_dec <= home_config[`HPR_DIR_BIT];
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   a_home_load: assert property (@(posedge clk) disable iff (!rstn)
      set_home |=> (cur_pos == $past(home_coord) && home_done)) else $error("home load");
   a_cradle_index: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == HPR_WAIT_Z && method == HPR_M_CRADLE && index_pulse) |=> state_q == HPR_SHIFT)
      else $error("cradle index");
   a_dog_slow: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == HPR_SEEK && dog_front && method != HPR_M_STOPPER) |=> creep_req)
      else $error("no creep");
   a_dir_map: assert property (@(posedge clk) disable iff (!rstn)
      1'b1 |=> move_dir_dec == $past(home_config[`HPR_DIR_BIT])) else $error("direction");
   a_start_clr: assert property (@(posedge clk) disable iff (!rstn)
      (start && !set_home && !ignore_home) |=> !home_done) else $error("done not cleared");
   a_ign_home: assert property (@(posedge clk) disable iff (!rstn)
      ignore_home |=> cur_pos == $past(home_coord)) else $error("ignore home");
   a_data_set: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == HPR_IDLE && start && method == HPR_M_DATA) |=> state_q == HPR_DONE)
      else $error("data set");
   a_stop_home: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == HPR_SEEK && method == HPR_M_STOPPER && stalled) |=> home_done)
      else $error("stopper");
   a_count_z: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == HPR_TRAVEL && dist_q == '0 && method == HPR_M_COUNT) |=> state_q == HPR_WAIT_Z)
      else $error("count travel");

   // ****************************************
   // Sequence checks
   // ****************************************
   // Views of the sequencer state; the motion flags are registered from the
   // next state, so they must always agree with these views
   logic  in_motion;
   logic  creeping;
   assign in_motion = (state_q != HPR_IDLE) && (state_q != HPR_DONE);
   assign creeping  = in_motion && (state_q != HPR_SEEK);

   // Dog type: rear edge seen while on the dog
   sequence s_dog_rear;
      (state_q == HPR_ON_DOG) && dog_rear && (method == HPR_M_DOG);
   endsequence
   // Rear-end reference: rear edge seen while on the dog
   sequence s_rear_ref_rear;
      (state_q == HPR_ON_DOG) && dog_rear && (method == HPR_M_REAR_REF);
   endsequence
   // Front-end reference: front edge seen while seeking
   sequence s_front_ref_front;
      (state_q == HPR_SEEK) && dog_front && (method == HPR_M_FRONT_REF);
   endsequence
   // Count type: front edge seen while seeking
   sequence s_count_front;
      (state_q == HPR_SEEK) && dog_front && (method == HPR_M_COUNT);
   endsequence
   // Waiting for the next index
   sequence s_wait_index;
      state_q == HPR_WAIT_Z;
   endsequence
   // Travelling the after-dog distance, freshly loaded
   sequence s_travel_loaded;
      (state_q == HPR_TRAVEL) && (dist_q == $past(after_dog_dist));
   endsequence
   // Index seen outside the cradle method, where the shift applies
   sequence s_index_shifting;
      (state_q == HPR_WAIT_Z) && index_pulse && (method != HPR_M_CRADLE);
   endsequence
   // Shift distance used up
   sequence s_shift_end;
      (state_q == HPR_SHIFT) && (dist_q == '0);
   endsequence

   // Dog type waits for the index only after the rear edge
   a_rear_index: assert property (@(posedge clk) disable iff (!rstn)
      s_dog_rear |=> s_wait_index) else $error("dog rear");

   // Rear-end reference travels from the rear edge, no index
   a_rear_travel: assert property (@(posedge clk) disable iff (!rstn)
      s_rear_ref_rear |=> s_travel_loaded) else $error("rear travel");

   // Front-end reference travels from the front edge
   a_front_travel: assert property (@(posedge clk) disable iff (!rstn)
      s_front_ref_front |=> s_travel_loaded) else $error("front travel");

   // Count type travels the after-dog distance first
   a_count_travel: assert property (@(posedge clk) disable iff (!rstn)
      s_count_front |=> s_travel_loaded) else $error("count front");

   // After the index the shift distance is loaded, outside the cradle method
   a_index_shift: assert property (@(posedge clk) disable iff (!rstn)
      s_index_shifting |=> (state_q == HPR_SHIFT && dist_q == $past(shift_dist))) else $error("index shift");

   // Shift finished: home fixed, coordinate loaded, flag raised
   a_shift_home: assert property (@(posedge clk) disable iff (!rstn)
      s_shift_end |=> (state_q == HPR_DONE && home_done && cur_pos == $past(home_coord))) else $error("shift home");

   // Move request stands exactly while a sequence runs
   a_move_flag: assert property (@(posedge clk) disable iff (!rstn)
      move_req == in_motion) else $error("move flag");

   // Busy flag stands exactly while a sequence runs
   a_busy_flag: assert property (@(posedge clk) disable iff (!rstn)
      homing_busy == in_motion) else $error("busy flag");

   // Creep stands from the dog onwards, never while seeking
   a_creep_flag: assert property (@(posedge clk) disable iff (!rstn)
      creep_req == creeping) else $error("creep flag");

   // Ignorance start never sets the axis moving
   a_ignore_rest: assert property (@(posedge clk) disable iff (!rstn)
      (start && !in_motion && method == HPR_M_IGNORE) |=> !in_motion) else $error("ignore moved");

endmodule : hpr_home_return

/* File: bench/hpr_axis_model.sv */
// Purpose: axis, dog switch and index model for the homing bench
// Assumes: one step every other cycle while motion is requested
// Notes:   dog covers steps 10 to 19, index at steps 6 mod 8, wall at 60
`timescale 1ns/10ps
module hpr_axis_model (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // Requests and busy from the sequencer, dog polarity from the bench
   input  wire logic move_req,
   input  wire logic homing_busy,
   input  wire logic pol,
   // Sensors and feedback
   output logic      pos_step,
   output logic      index_pulse,
   output logic      dog_in,
   output logic      axis_moving,
   output int        steps
);
   logic             on_dog;
   // Dog level follows the chosen polarity so idle never reads as detected
   assign on_dog      = (steps >= 10) && (steps < 20);
   assign dog_in      = pol ? on_dog : ~on_dog;
   // Mechanical wall stalls the axis, used by the stopper method
   assign axis_moving = move_req && (steps < 60);
   // Step train and once-per-revolution index
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pos_step    <= 1'b0;
         index_pulse <= 1'b0;
         steps       <= 0;
      end else begin
         pos_step    <= axis_moving && !pos_step;
         index_pulse <= pos_step && ((steps + 1) % 8 == 6);
         if (!homing_busy) steps <= 0; // Position counts from each start
         else if (pos_step) steps <= steps + 1;
      end
   end
endmodule : hpr_axis_model

/* File: bench/test_home_position_return_control.sv */
// Purpose: self-checking bench for the home position return sequencer
// Assumes: seed fixed, inputs driven 1 ns after the rising edge
// Notes:   step counts at completion are judged with a small window
`timescale 1ns/10ps
module test_home_position_return_control;
   import hpr_pkg::*;
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
   logic        clk = 0, rstn = 0, pol = 0;
   logic [15:0] home_config = 16'h0000;
   logic [31:0] home_coord = 32'h0, after_dog_dist = 32'h0, shift_dist = 32'h0, cur_pos;
   logic        auto_manual_select = 0, homing_program_command = 0, servo_on = 0;
   logic        dog_in, index_pulse, axis_moving, pos_step;
   logic        move_req, move_dir_dec, creep_req, home_done, homing_busy;
   int          steps, errors = 0, cmp_count = 0, cyc = 0;
   bit          ok;
   hpr_home_return #(.STOP_CYC(5)) dut_u (.*);
   hpr_axis_model axis_u (.*);
   // Clock and hang guard
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         errors++;
         give_verdict();
      end
   end
   task give_verdict;
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : give_verdict
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task start;
      homing_program_command = 1'b1;
      tick(1);
      homing_program_command = 1'b0;
   endtask : start
   task wait_done;
      ok = 0;
      for (int i = 0; i < 400 && !ok; i++) begin
         tick(1);
         ok = (home_done === 1'b1);
      end
   endtask : wait_done
   // Steps travelled from start to home, per method
   function automatic int exp_steps(input logic [2:0] m, input int ad, input int sh);
      int v;
      v = 11 + ad;
      while (v % 8 != 6) v++;
      case (m)
         HPR_M_DOG:       return 22 + sh;
         HPR_M_COUNT:     return v + sh;
         HPR_M_STOPPER:   return 60;
         HPR_M_REAR_REF:  return 20 + ad + sh;
         HPR_M_FRONT_REF: return 10 + ad + sh;
         HPR_M_CRADLE:    return 14;
         default:         return 0;
      endcase
   endfunction : exp_steps
   // One homing run with random direction, polarity and distances
   task run(input logic [2:0] m);
      int   e;
      logic d;
      d = $urandom % 2;
      pol = $urandom % 2;
      after_dog_dist = ($urandom % 4) * 2 + 1; // Odd keeps travel end off an index
      shift_dist = $urandom % 8;
      home_coord = $urandom;
      home_config = {7'h00, pol, 3'h0, d, 1'b0, m};
      e = exp_steps(m, after_dog_dist, shift_dist);
      tick(1);
      start();
      tick(1);
      if (m != HPR_M_DATA) begin
         `CHK(home_done, 1'b0)
         `CHK(move_dir_dec, d)
         `CHK(homing_busy, 1'b1)
      end
      wait_done();
      `CHK(ok, 1'b1)
      `CHK(move_req, 1'b0)
      `CHK(creep_req, 1'b0)
      `CHK(cur_pos, home_coord)
      `CHK((steps >= e && steps <= e + 2), 1'b1)
   endtask : run
   initial begin
      void'($urandom(36));
      tick(3);
      rstn = 1'b1;
      `CHK(home_done, 1'b0)
      // Start without manual mode must be ignored
      start();
      tick(2);
      `CHK(homing_busy, 1'b0)
      auto_manual_select = 1'b1;
      for (int r = 0; r < 3; r++)
         for (int m = 0; m < 8; m++)
            if (m != 4) run(m[2:0]);
      // Ignorance: start only clears done, servo-on fixes home
      home_config = 16'h0004;
      home_coord = $urandom;
      start();
      tick(2);
      `CHK(homing_busy, 1'b0)
      servo_on = 1'b1;
      tick(4);
      `CHK(home_done, 1'b1)
      `CHK(cur_pos, home_coord)
      give_verdict();
   end
endmodule : test_home_position_return_control
